// [display_timing_pkg.sv]
// Shared offsets, field positions, reset values and types of the display timing block.
package display_timing_pkg;

   // ==========================================================================
   // Register offsets (byte addresses on the APB side).
   // ==========================================================================
   localparam logic [15:0] GEN_CFG_OFF    = 16'h8304;
   localparam logic [15:0] TIMING_CFG_OFF = 16'h8308;
   localparam logic [15:0] IRQ_STATUS_OFF = 16'h8310;
   localparam logic [15:0] IRQ_MASK_OFF   = 16'h8314;

   // ==========================================================================
   // General configuration fields.
   // ==========================================================================
   localparam int FIFO_LOAD_BIT  = 0;
   localparam int CURSOR_EN_BIT  = 1;
   localparam logic [31:0] GEN_CFG_WMASK = 32'h0000_0003;

   // ==========================================================================
   // Timing configuration fields.
   // ==========================================================================
   localparam int VIRQ_PEND_BIT   = 31;
   localparam int VERT_INACT_BIT  = 30;
   localparam int LINE_INACT_BIT  = 29;
   localparam int MON_INPUT_BIT   = 27;
   localparam int PIX_DOUBLE_BIT  = 15;
   localparam int INTERLACE_BIT   = 14;
   localparam int PLANAR_BIT      = 13;
   localparam int CENTERING_BIT   = 12;
   localparam int VIRQ_EN_BIT     = 6;
   localparam logic [31:0] TIMING_CFG_WMASK = 32'h000F_FFFF;

   // ==========================================================================
   // Interrupt status and mask fields.
   // ==========================================================================
   localparam int IRQ_VSYNC_BIT   = 0;
   localparam int IRQ_MONITOR_BIT = 1;
   localparam logic [31:0] IRQ_WMASK = 32'h0000_0003;

   // ==========================================================================
   // Reset values.
   // ==========================================================================
   localparam logic [31:0] GEN_CFG_RST    = 32'h0000_0000;
   localparam logic [31:0] TIMING_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] IRQ_STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] IRQ_MASK_RST   = 32'h0000_0000;

   // ==========================================================================
   // Widths and types.
   // ==========================================================================
   localparam int PIXEL_W = 24;
   localparam int SCAN_W  = 5;

   // Scan status from the timing generator, all outside the pclk domain.
   typedef struct packed {
      logic vsync;
      logic vert_inactive;
      logic line_inactive;
      logic line_border;
      logic monitor_pin;
   } scan_in_t;

   // Horizontal doubling phase: first showing of a pixel or its repeat.
   typedef enum logic {
      PH_FIRST  = 1'b0,
      PH_REPEAT = 1'b1
   } pix_phase_t;

endpackage

// [scan_status_sync.sv]
// Two-stage synchroniser for the scan status and monitor channel pin.
`timescale 1ns/1ns
`default_nettype none
module scan_status_sync
   import display_timing_pkg::*;
(
   // Clock and reset.
   input  wire logic     pclk,
   input  wire logic     presetn,
   // Asynchronous levels in, synchronised levels out.
   input  wire scan_in_t async_in,
   output scan_in_t      sync_out
);

   logic [SCAN_W-1:0] raw;
   logic [SCAN_W-1:0] meta_r;
   logic [SCAN_W-1:0] sync_r;

   assign raw      = async_in;
   assign sync_out = sync_r;

   // ==========================================================================
   // One pair of flops per bit; the first flop feeds only the second.
   // ==========================================================================
   for (genvar i = 0; i < SCAN_W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta_r[i] <= 1'b0;
            sync_r[i] <= 1'b0;
         end else begin
            meta_r[i] <= raw[i];
            sync_r[i] <= meta_r[i];
         end
      end
   end

endmodule
`default_nettype wire

// [display_timing_config_status.sv]
// Display timing configuration and status block with APB register access.
//
// Contract
// RULE_01: Cursor enable set overlays the hardware cursor; clear shows no cursor.
// RULE_02: FIFO load enable clear stops all FIFO writes and reads; set refills it.
// RULE_03: Software powers down panel and blanks CRT before clearing FIFO load.
// RULE_04: Bit 31 reads one while a vertical interrupt is pending.
// RULE_05: Bit 30 reads zero in active vertical region, one otherwise.
// RULE_06: Bit 29 reads zero in active line region, one otherwise.
// RULE_07: Bit 27 returns the sampled monitor channel input pin level.
// RULE_08: Software writes zero to reserved bit 28 and field 26:20.
// RULE_09: Pixel doubling shows each fetched pixel twice horizontally.
// RULE_10: With doubling, software keeps normal timing and halves stored pixels.
// RULE_11: Interlace bit selects interlaced scanning when set.
// RULE_12: Software powers down the panel before enabling interlace.
// RULE_13: Software sets planar mode for every planar display mode.
// RULE_14: Centering set drives panel display enable over border and active.
// RULE_15: Centering clear drives panel display enable only over active.
// RULE_16: Timing register at 8308h, low twenty bits zero after reset.
// RULE_17: Interrupt enable raises pending at vsync; clearing it clears pending.
// RULE_18: Status bits and monitor input are synchronised before being read.
`timescale 1ns/1ns
`default_nettype none
module display_timing_config_status
   import display_timing_pkg::*;
(
   // Clock and reset.
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave.
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [15:0]        paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Scan status from the timing generator.
   input  wire scan_in_t           scan_in,
   // Display FIFO.
   input  wire logic               fifo_level_low,
   input  wire logic [PIXEL_W-1:0] fifo_data,
   output logic                    fifo_fill_req,
   output logic                    fifo_rd_en,
   // Hardware cursor source.
   input  wire logic               cursor_hit,
   input  wire logic [PIXEL_W-1:0] cursor_color,
   // Display side.
   output logic      [PIXEL_W-1:0] pixel_out,
   output logic                    panel_display_enable,
   output logic                    interlace_enable,
   output logic                    planar_mode_select,
   // Interrupt.
   output logic                    irq
);

   // ==========================================================================
   // Declarations.
   // ==========================================================================
   scan_in_t           scan_s;
   logic [31:0]        gen_cfg_r;
   logic [31:0]        timing_cfg_r;
   logic [31:0]        irq_status_r;
   logic [31:0]        irq_mask_r;
   logic [31:0]        irq_status_nxt;
   logic [31:0]        prdata_r;
   logic [31:0]        rd_nxt;
   logic [31:0]        byte_mask;
   logic [31:0]        irq_events;
   logic               hit;
   logic               wr_acc;
   logic               rd_setup;
   logic               vsync_d_r;
   logic               monitor_d_r;
   logic               vsync_rise;
   logic               vert_irq_pending_r;
   logic               hw_cursor_enable;
   logic               display_fifo_load_enable;
   logic               horizontal_pixel_doubling;
   logic               panel_centering_enable;
   logic               vertical_irq_enable;
   logic               line_active;
   pix_phase_t         phase_r;
   logic [PIXEL_W-1:0] fetched_r;
   logic [PIXEL_W-1:0] pixel_src;
   logic [PIXEL_W-1:0] pixel_r;
   logic               panel_de_r;

   // ==========================================================================
   // Synchronisers for every scan status level from the timing generator; FIFO and cursor inputs are used unsynchronised.
   // ==========================================================================
   scan_status_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (scan_in),
      .sync_out (scan_s)
   );

   // Field views of the configuration registers.
   assign hw_cursor_enable          = gen_cfg_r[CURSOR_EN_BIT];
   assign display_fifo_load_enable  = gen_cfg_r[FIFO_LOAD_BIT];
   assign horizontal_pixel_doubling = timing_cfg_r[PIX_DOUBLE_BIT];
   assign panel_centering_enable    = timing_cfg_r[CENTERING_BIT];
   assign vertical_irq_enable       = timing_cfg_r[VIRQ_EN_BIT];
   assign interlace_enable          = timing_cfg_r[INTERLACE_BIT]; // RULE_11
   assign planar_mode_select        = timing_cfg_r[PLANAR_BIT];
   assign line_active               = !scan_s.line_inactive && !scan_s.vert_inactive;

   // ==========================================================================
   // APB decode. Zero wait states; unmapped addresses answer with pslverr.
   // ==========================================================================
   assign hit = (paddr == GEN_CFG_OFF) || (paddr == TIMING_CFG_OFF) ||
                (paddr == IRQ_STATUS_OFF) || (paddr == IRQ_MASK_OFF);
   assign wr_acc    = psel && penable && pwrite && hit;
   assign rd_setup  = psel && !penable && !pwrite;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !hit;
   assign prdata    = prdata_r;
   assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // Read mux; status bits come only from synchronised copies.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (paddr)
         GEN_CFG_OFF: begin
            rd_nxt = gen_cfg_r;
         end
         TIMING_CFG_OFF: begin
            rd_nxt                 = timing_cfg_r;                // RULE_16
            rd_nxt[VIRQ_PEND_BIT]  = vert_irq_pending_r;          // RULE_04
            rd_nxt[VERT_INACT_BIT] = scan_s.vert_inactive;        // RULE_05
            rd_nxt[LINE_INACT_BIT] = scan_s.line_inactive;        // RULE_06
            rd_nxt[MON_INPUT_BIT]  = scan_s.monitor_pin;          // RULE_07
         end
         IRQ_STATUS_OFF: begin
            rd_nxt = irq_status_r;
         end
         IRQ_MASK_OFF: begin
            rd_nxt = irq_mask_r;
         end
         default: begin
            rd_nxt = 32'h0000_0000;
         end
      endcase
   end

   // Read data is captured in the setup cycle so it stands as a flop in access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_r <= rd_nxt; // RULE_18
      end
   end

   // ==========================================================================
   // Configuration registers. Reserved and read-only bits drop writes.
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_cfg_r <= GEN_CFG_RST;
      end else if (wr_acc && paddr == GEN_CFG_OFF) begin
         gen_cfg_r <= (gen_cfg_r & ~(byte_mask & GEN_CFG_WMASK)) |
                      (pwdata & byte_mask & GEN_CFG_WMASK);
      end
   end

   // The upper field holds no storage, so stray writes there cannot stick.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing_cfg_r <= TIMING_CFG_RST; // RULE_16
      end else if (wr_acc && paddr == TIMING_CFG_OFF) begin
         timing_cfg_r <= (timing_cfg_r & ~(byte_mask & TIMING_CFG_WMASK)) |
                         (pwdata & byte_mask & TIMING_CFG_WMASK); // RULE_08
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= IRQ_MASK_RST;
      end else if (wr_acc && paddr == IRQ_MASK_OFF) begin
         irq_mask_r <= (irq_mask_r & ~(byte_mask & IRQ_WMASK)) |
                       (pwdata & byte_mask & IRQ_WMASK);
      end
   end

   // ==========================================================================
   // Vertical interrupt pending, set at the vsync edge, cleared by the enable.
   // ==========================================================================
   assign vsync_rise = scan_s.vsync && !vsync_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vsync_d_r   <= 1'b0;
         monitor_d_r <= 1'b0;
      end else begin
         vsync_d_r   <= scan_s.vsync;
         monitor_d_r <= scan_s.monitor_pin;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vert_irq_pending_r <= 1'b0;
      end else if (!vertical_irq_enable) begin
         vert_irq_pending_r <= 1'b0; // RULE_17
      end else if (vsync_rise) begin
         vert_irq_pending_r <= 1'b1; // RULE_17
      end
   end

   // ==========================================================================
   // Sticky interrupt status, write one to clear; a new event beats the clear.
   // ==========================================================================
   always_comb begin
      irq_events                  = 32'h0000_0000;
      irq_events[IRQ_VSYNC_BIT]   = vsync_rise;
      irq_events[IRQ_MONITOR_BIT] = scan_s.monitor_pin ^ monitor_d_r;
      irq_status_nxt              = irq_status_r;
      if (wr_acc && paddr == IRQ_STATUS_OFF) begin
         irq_status_nxt = irq_status_r & ~(pwdata & byte_mask);
      end
      irq_status_nxt = (irq_status_nxt | irq_events) & IRQ_WMASK;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_r <= IRQ_STATUS_RST;
      end else begin
         irq_status_r <= irq_status_nxt;
      end
   end

   assign irq = |(irq_status_r & irq_mask_r);

   // ==========================================================================
   // FIFO control. With loading off nothing touches the FIFO at all.
   // ==========================================================================
   assign fifo_fill_req = display_fifo_load_enable && fifo_level_low; // RULE_02
   assign fifo_rd_en    = display_fifo_load_enable && line_active &&
                          (!horizontal_pixel_doubling || phase_r == PH_FIRST); // RULE_02 RULE_09

   // Doubling phase restarts on every line so the first pixel is never halved.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= PH_FIRST;
      end else if (!line_active || !horizontal_pixel_doubling) begin
         phase_r <= PH_FIRST;
      end else begin
         phase_r <= (phase_r == PH_FIRST) ? PH_REPEAT : PH_FIRST; // RULE_09
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetched_r <= '0;
      end else if (fifo_rd_en) begin
         fetched_r <= fifo_data;
      end
   end

   // A repeat cycle shows the held pixel a second time.
   assign pixel_src = fifo_rd_en ? fifo_data : fetched_r; // RULE_09

   // ==========================================================================
   // Pixel output with cursor overlay; black outside the active area.
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pixel_r <= '0;
      end else if (!line_active) begin
         pixel_r <= '0;
      end else if (hw_cursor_enable && cursor_hit) begin
         pixel_r <= cursor_color; // RULE_01
      end else begin
         pixel_r <= pixel_src; // RULE_01
      end
   end

   assign pixel_out = pixel_r;

   // Panel enable widens over the border only when centering is on.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_de_r <= 1'b0;
      end else begin
         panel_de_r <= !scan_s.vert_inactive &&
                       (!scan_s.line_inactive ||
                        (panel_centering_enable && scan_s.line_border)); // RULE_14 RULE_15
      end
   end

   assign panel_display_enable = panel_de_r;

   // ==========================================================================
   // Assertions.
   // ==========================================================================
   cursor_overlay_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
      hw_cursor_enable && cursor_hit && line_active |=> pixel_out == $past(cursor_color))
      else $error("cursor colour not shown while enabled");

   cursor_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
      !hw_cursor_enable && line_active |=> pixel_out == $past(pixel_src))
      else $error("cursor shown while disabled");

   fifo_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
      !gen_cfg_r[FIFO_LOAD_BIT] |-> !fifo_rd_en && !fifo_fill_req)
      else $error("fifo accessed with loading disabled");

   pending_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
      psel && penable && !pwrite && paddr == TIMING_CFG_OFF |->
      prdata[VIRQ_PEND_BIT] == $past(vert_irq_pending_r))
      else $error("pending bit read wrong");

   vert_status_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
      psel && penable && !pwrite && paddr == TIMING_CFG_OFF |->
      prdata[VERT_INACT_BIT] == $past(scan_s.vert_inactive))
      else $error("vertical inactive bit read wrong");

   line_status_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
      psel && penable && !pwrite && paddr == TIMING_CFG_OFF |->
      prdata[LINE_INACT_BIT] == $past(scan_s.line_inactive))
      else $error("line inactive bit read wrong");

   monitor_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      psel && penable && !pwrite && paddr == TIMING_CFG_OFF |->
      prdata[MON_INPUT_BIT] == $past(scan_s.monitor_pin) && prdata[28] == 1'b0)
      else $error("monitor input bit read wrong");

   double_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
      fifo_rd_en && horizontal_pixel_doubling && line_active ##1
      line_active && $stable(timing_cfg_r) |-> !fifo_rd_en)
      else $error("doubled pixel fetched twice in a row");

   centering_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
      panel_centering_enable && scan_s.line_border && !scan_s.vert_inactive |=> panel_display_enable)
      else $error("panel enable low over border with centering");

   centering_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
      !panel_centering_enable && scan_s.line_inactive |=> !panel_display_enable)
      else $error("panel enable high outside active area");

   timing_reset_a: assert property (@(posedge pclk) // RULE_16
      $rose(presetn) |-> timing_cfg_r[19:0] == 20'h00000)
      else $error("timing register low bits not zero after reset");

   vertical_irq_pending_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
      vertical_irq_enable && vsync_rise ##1 vertical_irq_enable |-> vert_irq_pending_r)
      else $error("pending not raised at vsync");

   vertical_irq_pending_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
      !vertical_irq_enable |=> !vert_irq_pending_r)
      else $error("pending not cleared by disable");

   status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      vsync_rise |=> irq_status_r[IRQ_VSYNC_BIT])
      else $error("vsync event lost");

   cover_doubling_c: cover property (@(posedge pclk) disable iff (!presetn)
      horizontal_pixel_doubling && fifo_rd_en ##1 !fifo_rd_en && line_active);
   cover_pending_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(vert_irq_pending_r));
   cover_centering_c: cover property (@(posedge pclk) disable iff (!presetn)
      panel_display_enable && scan_s.line_inactive);
   cover_irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule
`default_nettype wire

// [scan_partner.sv]
// Behavioural scan timing source and show-ahead display FIFO facing the block.
`timescale 1ns/1ns
`default_nettype none
module scan_partner
   import display_timing_pkg::*;
(
   // Clock and bench control.
   input  wire logic               pclk,
   input  wire logic               run,
   input  wire scan_in_t           hold,
   input  wire logic               fifo_rd_en,
   // Levels towards the block.
   output scan_in_t                scan,
   output logic      [PIXEL_W-1:0] fifo_data
);
   logic [3:0] pos_r = 4'h0;
   // ==========================================================================
   // Line timing.
   // ==========================================================================
   // A line is 8 active, 2 border and 2 retrace cycles; it is kept short so
   // that a whole number of lines fits a short count window.
   always_ff @(posedge pclk) begin
      pos_r <= (pos_r == 4'hB) ? 4'h0 : pos_r + 4'h1;
   end
   // Outside a run the bench holds every level itself.
   always_comb begin
      scan = hold;
      if (run) begin
         scan.line_inactive = (pos_r > 4'h7);
         scan.line_border   = (pos_r > 4'h7) && (pos_r < 4'hA);
      end
   end
   // The head word advances only when the block takes a pixel.
   always @(posedge pclk) begin
      if (fifo_rd_en === 1'b1) begin
         fifo_data <= fifo_data + 24'h000001;
      end
   end
   initial fifo_data = 24'h000000;
endmodule
`default_nettype wire

// [display_timing_config_status_tb.sv]
// Self-checking bench for the display timing configuration and status block.
`timescale 1ns/1ns
`default_nettype none
module display_timing_config_status_tb;
   import display_timing_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, run;
   logic               fifo_level_low, fifo_fill_req, fifo_rd_en, cursor_hit, irq;
   logic               panel_display_enable, interlace_enable, planar_mode_select;
   logic [15:0]        paddr;
   logic [31:0]        pwdata, prdata, rnd, e;
   logic [3:0]         pstrb;
   logic [PIXEL_W-1:0] fifo_data, cursor_color, pixel_out;
   scan_in_t           scan_in, hold;
   logic [32:0]        exp_q[$];
   int                 err_count = 0, cmp_count = 0, cycles = 0, seed = 5;

   display_timing_config_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .scan_in, .fifo_level_low, .fifo_data, .fifo_fill_req,
      .fifo_rd_en, .cursor_hit, .cursor_color, .pixel_out, .panel_display_enable,
      .interlace_enable, .planar_mode_select, .irq);
   scan_partner far (.pclk, .run, .hold, .fifo_rd_en, .scan(scan_in), .fifo_data);

   // ==========================================================================
   // Shared tasks.
   // ==========================================================================
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; a read notes {pslverr, prdata} for the monitor.
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [32:0] x);
      exp_q.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask
   // Counts pixel reads over two whole lines.
   task automatic count_rd(input int exp);
      int k;
      k = 0;
      repeat (24) begin
         @(negedge pclk);
         if (fifo_rd_en === 1'b1) k++;
      end
      chk(k, exp);
   endtask
   task automatic settle;
      repeat (4) @(negedge pclk);
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Read monitor: the answer is taken at the edge that samples pready high.
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) chk({pslverr, prdata}, exp_q.pop_front());
   end
   // Hang guard, well above the length of the sequence.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ==========================================================================
   // Main sequence.
   // ==========================================================================
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, run, hold, cursor_hit} = '0;
      fifo_level_low = 1'b1;
      cursor_color = 24'hA5C3E1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(TIMING_CFG_OFF, {1'b0, TIMING_CFG_RST});
      rd(GEN_CFG_OFF, 33'h0);
      rd(16'h8300, 33'h1_0000_0000);
      // Random control bits; ones written to read-only bits must not stick.
      rnd = $random(seed) & 32'h000F_FFBF;
      apb(1'b1, TIMING_CFG_OFF, rnd | 32'hE800_0000);
      rd(TIMING_CFG_OFF, {1'b0, rnd});
      settle();
      chk(interlace_enable, rnd[14]);
      chk(planar_mode_select, rnd[13]);
      // Every combination of the two inactive flags, with the pin following.
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         hold <= '{1'b0, i[0], i[1], 1'b0, i[0] ^ i[1]};
         settle();
         e = rnd | {1'b0, i[0], i[1], 1'b0, i[0] ^ i[1], 27'h0};
         rd(TIMING_CFG_OFF, {1'b0, e});
      end
      // Pin changes raised a masked event, then unmasked and cleared.
      settle();
      chk(irq, 1'b0);
      apb(1'b1, IRQ_MASK_OFF, 32'h3);
      settle();
      chk(irq, 1'b1);
      apb(1'b1, IRQ_STATUS_OFF, 32'h2);
      settle();
      chk(irq, 1'b0);
      // Vertical interrupt enabled, then a sync pulse, then enable cleared.
      apb(1'b1, TIMING_CFG_OFF, 32'h0000_0040);
      @(posedge pclk);
      hold <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      settle();
      @(posedge pclk) hold <= '0;
      settle();
      rd(TIMING_CFG_OFF, 33'h0_8000_0040);
      chk(irq, 1'b1);
      apb(1'b1, TIMING_CFG_OFF, 32'h0);
      rd(TIMING_CFG_OFF, 33'h0);
      apb(1'b1, IRQ_STATUS_OFF, 32'h1);
      // Cursor and FIFO load in the active region, then centering over the border.
      apb(1'b1, GEN_CFG_OFF, 32'h3);
      apb(1'b1, TIMING_CFG_OFF, 32'h0000_1000);
      cursor_hit <= 1'b1;
      settle();
      chk(pixel_out, cursor_color);
      chk(fifo_fill_req, 1'b1);
      @(posedge pclk) hold <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      settle();
      chk(panel_display_enable, 1'b1);
      apb(1'b1, TIMING_CFG_OFF, 32'h0);
      settle();
      chk(panel_display_enable, 1'b0);
      // Load disabled: no FIFO traffic while lines run; then load on, then doubling halves the reads.
      apb(1'b1, GEN_CFG_OFF, 32'h0);
      run <= 1'b1;
      settle();
      chk(fifo_fill_req, 1'b0);
      count_rd(0);
      apb(1'b1, GEN_CFG_OFF, 32'h1);
      repeat (12) @(negedge pclk);
      count_rd(16);
      apb(1'b1, TIMING_CFG_OFF, 32'h0000_8000);
      repeat (12) @(negedge pclk);
      count_rd(8);
      tally_and_finish();
   end
endmodule
`default_nettype wire
